/* File: include/smbt_defines.vh */
`ifndef SMBT_DEFINES_VH
`define SMBT_DEFINES_VH

// Register indices on the host port.
`define SMBT_AW 4
`define SMBT_DW 8
`define SMBT_ADDR_OWN 4'h0
`define SMBT_ADDR_CTRL 4'h1
`define SMBT_ADDR_STAT 4'h2
`define SMBT_ADDR_DATA 4'h3
`define SMBT_ADDR_INT_STAT 4'h4
`define SMBT_ADDR_INT_EN 4'h5
`define SMBT_ADDR_INT_CLR 4'h6

// Control register fields.
`define SMBT_CTRL_ACK 0
`define SMBT_CTRL_MSEL 1

// Bus status register fields.
`define SMBT_STAT_DONE 0
`define SMBT_STAT_AAT 1
`define SMBT_STAT_BUSY 2
`define SMBT_STAT_RXNAK 3
`define SMBT_STAT_TTX 4

// Interrupt status, enable and clear layout.
`define SMBT_INT_W 4
`define SMBT_INT_DONE 0
`define SMBT_INT_AAT 1
`define SMBT_INT_STOP 2
`define SMBT_INT_NAK 3

// Reset values.
`define SMBT_OWN_RST 7'h00
`define SMBT_BYTE_RST 8'h00
`define SMBT_INT_RST 4'h0

// Bit counting within one byte.
`define SMBT_CNT_W 4
`define SMBT_CNT_ZERO 4'h0
`define SMBT_CNT_ONE 4'h1
`define SMBT_CNT_FULL 4'h8

`endif

/* File: rtl/smbt_sync.v */
`timescale 1ns/10ps
`default_nettype none

module smbt_sync #(
  parameter WIDTH = 2
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Asynchronous levels in, synchronised levels out
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_q
);

  reg [WIDTH-1:0] meta_q;

  // Lines idle high, so both stages reset to one.
  always @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= {WIDTH{1'b1}};
      sync_q <= {WIDTH{1'b1}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

endmodule // smbt_sync

`default_nettype wire

/* File: rtl/smbt_byte_flow.v */
// Summary of operation
// - With interrupts enabled, every finished data byte either direction raises the interrupt.
// - Byte-complete flag sets at every data byte end, interrupts enabled or not.
// - Receive copies the shift register into the bus data register as each data ack bit starts; transmit reloads it from there as the ack ends.
// - Data states move on to the next byte without waiting on the host.
// - Entering STOP as controller requests a STOP from the line generator; otherwise none.
// - STOP advances to IDLE after one cycle, or to HEADER if a START is detected in that cycle.
// - Each received data byte's acknowledge slot, and that of a header matching the own address, drives SDA with the ack drive value.
// - Host clears controller mode select to ask for STOP; device then requests it from the line generator.
// - Own address match at header acknowledge switches to target and sets flag.
// - Transmit returns to sending on each ack except as controller with mode select cleared; stops on missing ack or STOP.
`include "smbt_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module smbt_byte_flow (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Host register port
  input wire [`SMBT_AW-1:0] reg_addr,
  input wire [`SMBT_DW-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`SMBT_DW-1:0] reg_rdata_q,
  // Interrupt
  output wire irq,
  // SMBus lines
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe_n_q,
  // Requests to the line generator
  output wire gen_start_req,
  output wire gen_stop_req
);

  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_HEADER = 8'h02;
  localparam [7:0] ST_ACK_HEADER = 8'h04;
  localparam [7:0] ST_RCV_DATA = 8'h08;
  localparam [7:0] ST_ACK_DATA = 8'h10;
  localparam [7:0] ST_XMIT_DATA = 8'h20;
  localparam [7:0] ST_WAIT_ACK = 8'h40;
  localparam [7:0] ST_STOP = 8'h80;

  wire [1:0] line_sync;
  wire scl_s;
  wire sda_s;
  reg scl_prev_q;
  reg sda_prev_q;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;

  reg [7:0] state_q;
  reg [`SMBT_CNT_W-1:0] cnt_q;
  reg [7:0] shift_q;
  reg [7:0] hdr_q;
  reg [7:0] data_q;
  reg [6:0] own_q;
  reg ack_val_q;
  reg msel_q;
  reg ctl_act_q;
  reg aat_q;
  reg busy_q;
  reg [`SMBT_INT_W-1:0] int_stat_q;
  reg [`SMBT_INT_W-1:0] int_en_q;

  reg [7:0] state_d;
  reg [`SMBT_CNT_W-1:0] cnt_d;
  reg [7:0] shift_d;
  reg drive_low_d;
  reg load_data;
  reg load_hdr;
  reg set_done;
  reg set_aat;
  reg set_nak;
  reg enter_target;

  wire wr_own;
  wire wr_ctrl;
  wire wr_data;
  wire wr_int_en;
  wire wr_int_clr;
  wire hdr_match;
  wire ack_missing;
  wire [`SMBT_INT_W-1:0] int_set;
  wire [`SMBT_DW-1:0] ctrl_view;
  wire [`SMBT_DW-1:0] stat_view;

  smbt_sync #(
    .WIDTH(2)
  ) u_line_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in({scl_in, sda_in}),
    .sync_q(line_sync)
  );

  assign scl_s = line_sync[1];
  assign sda_s = line_sync[0];
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  // SDA moving while SCL stays high marks START or STOP.
  assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  assign hdr_match = (shift_q[7:1] == own_q);
  // The bit shifted in at the acknowledge clock sits in the low bit.
  assign ack_missing = shift_q[0];

  assign sda_out = 1'b0;

  always @(posedge clk_sys) begin
    if (rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // Next state, evaluated on each falling SCL edge.
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    drive_low_d = 1'b0;
    load_data = 1'b0;
    load_hdr = 1'b0;
    set_done = 1'b0;
    set_aat = 1'b0;
    set_nak = 1'b0;
    enter_target = 1'b0;
    case (state_q)
      ST_IDLE: begin
        state_d = ST_IDLE;
      end
      ST_HEADER: begin
        if (cnt_q == `SMBT_CNT_FULL) begin
          state_d = ST_ACK_HEADER;
          cnt_d = `SMBT_CNT_ZERO;
          load_hdr = 1'b1;
          if (hdr_match) begin
            enter_target = 1'b1;
            set_aat = 1'b1;
            drive_low_d = ~ack_val_q;
          end
        end else begin
          drive_low_d = ctl_act_q & ~shift_q[7];
        end
      end
      ST_ACK_HEADER: begin
        if (ctl_act_q) begin
          if (ack_missing) begin
            state_d = ST_STOP;
            set_nak = 1'b1;
          end else if (hdr_q[0]) begin
            state_d = ST_RCV_DATA;
          end else begin
            state_d = ST_XMIT_DATA;
            shift_d = data_q;
            drive_low_d = ~data_q[7];
          end
        end else if (aat_q) begin
          if (hdr_q[0]) begin
            state_d = ST_XMIT_DATA;
            shift_d = data_q;
            drive_low_d = ~data_q[7];
          end else begin
            state_d = ST_RCV_DATA;
          end
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_RCV_DATA: begin
        if (cnt_q == `SMBT_CNT_FULL) begin
          state_d = ST_ACK_DATA;
          cnt_d = `SMBT_CNT_ZERO;
          load_data = 1'b1;
          set_done = 1'b1;
          drive_low_d = ~ack_val_q;
        end
      end
      ST_ACK_DATA: begin
        // No wait for the host to have taken the byte.
        if (ctl_act_q & ~msel_q) begin
          state_d = ST_STOP;
        end else begin
          state_d = ST_RCV_DATA;
        end
      end
      ST_XMIT_DATA: begin
        if (cnt_q == `SMBT_CNT_FULL) begin
          state_d = ST_WAIT_ACK;
          cnt_d = `SMBT_CNT_ZERO;
          set_done = 1'b1;
        end else begin
          drive_low_d = ~shift_q[7];
        end
      end
      ST_WAIT_ACK: begin
        if (ack_missing) begin
          state_d = ctl_act_q ? ST_STOP : ST_IDLE;
          set_nak = 1'b1;
        end else if (ctl_act_q & ~msel_q) begin
          state_d = ST_STOP;
        end else begin
          // The next byte is taken from the data register at the fall that ends the ack bit.
          state_d = ST_XMIT_DATA;
          shift_d = data_q;
          drive_low_d = ~data_q[7];
        end
      end
      ST_STOP: begin
        state_d = ST_STOP;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Protocol state, counters and line drive.
  always @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= `SMBT_CNT_ZERO;
      shift_q <= `SMBT_BYTE_RST;
      hdr_q <= `SMBT_BYTE_RST;
      sda_oe_n_q <= 1'b1;
      ctl_act_q <= 1'b0;
      aat_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (stop_det) begin
      // A STOP on the line ends everything, including the target session.
      state_q <= ST_IDLE;
      cnt_q <= `SMBT_CNT_ZERO;
      sda_oe_n_q <= 1'b1;
      ctl_act_q <= 1'b0;
      aat_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (start_det) begin
      state_q <= ST_HEADER;
      cnt_q <= `SMBT_CNT_ZERO;
      shift_q <= data_q;
      sda_oe_n_q <= 1'b1;
      ctl_act_q <= msel_q;
      aat_q <= 1'b0;
      busy_q <= 1'b1;
    end else if (state_q == ST_STOP) begin
      // The generator has been asked for STOP; the machine goes idle at once.
      state_q <= ST_IDLE;
      sda_oe_n_q <= 1'b1;
      ctl_act_q <= 1'b0;
    end else if (scl_fall) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      sda_oe_n_q <= ~drive_low_d;
      if (load_hdr) begin
        hdr_q <= shift_q;
      end
      if (enter_target) begin
        ctl_act_q <= 1'b0;
      end
      if (set_aat) begin
        aat_q <= 1'b1;
      end
    end else if (scl_rise) begin
      shift_q <= {shift_q[6:0], sda_s};
      if ((state_q == ST_HEADER) | (state_q == ST_RCV_DATA) | (state_q == ST_XMIT_DATA)) begin
        cnt_q <= cnt_q + `SMBT_CNT_ONE;
      end
    end
  end

  // The STOP request lasts the one cycle spent in STOP, controller only.
  assign gen_stop_req = (state_q == ST_STOP) & ctl_act_q;
  assign gen_start_req = msel_q & ~busy_q & ~ctl_act_q;

  // Host register port.
  assign wr_own = reg_wr & (reg_addr == `SMBT_ADDR_OWN);
  assign wr_ctrl = reg_wr & (reg_addr == `SMBT_ADDR_CTRL);
  assign wr_data = reg_wr & (reg_addr == `SMBT_ADDR_DATA);
  assign wr_int_en = reg_wr & (reg_addr == `SMBT_ADDR_INT_EN);
  assign wr_int_clr = reg_wr & (reg_addr == `SMBT_ADDR_INT_CLR);

  always @(posedge clk_sys) begin
    if (rst) begin
      own_q <= `SMBT_OWN_RST;
      ack_val_q <= 1'b0;
      msel_q <= 1'b0;
      data_q <= `SMBT_BYTE_RST;
      int_en_q <= `SMBT_INT_RST;
    end else begin
      if (wr_own) begin
        own_q <= reg_wdata[7:1];
      end
      if (wr_ctrl) begin
        ack_val_q <= reg_wdata[`SMBT_CTRL_ACK];
        msel_q <= reg_wdata[`SMBT_CTRL_MSEL];
      end
      // Being addressed drops controller mode even against a host write.
      if (scl_fall & enter_target & ~stop_det & ~start_det & (state_q != ST_STOP)) begin
        msel_q <= 1'b0;
      end
      if (wr_data) begin
        data_q <= reg_wdata;
      end
      // A received byte lands over any host write in the same cycle.
      if (scl_fall & load_data & ~stop_det & ~start_det & (state_q != ST_STOP)) begin
        data_q <= shift_q;
      end
      if (wr_int_en) begin
        int_en_q <= reg_wdata[`SMBT_INT_W-1:0];
      end
    end
  end

  // Sticky event flags; a new event wins over a clear in the same cycle.
  assign int_set[`SMBT_INT_DONE] = scl_fall & set_done & ~stop_det & ~start_det
                                   & (state_q != ST_STOP);
  assign int_set[`SMBT_INT_AAT] = scl_fall & set_aat & ~stop_det & ~start_det
                                  & (state_q != ST_STOP);
  assign int_set[`SMBT_INT_STOP] = stop_det;
  assign int_set[`SMBT_INT_NAK] = scl_fall & set_nak & ~stop_det & ~start_det
                                  & (state_q != ST_STOP);

  genvar gi;
  generate
    for (gi = 0; gi < `SMBT_INT_W; gi = gi + 1) begin : g_int
      always @(posedge clk_sys) begin
        if (rst) begin
          int_stat_q[gi] <= 1'b0;
        end else if (int_set[gi]) begin
          int_stat_q[gi] <= 1'b1;
        end else if (wr_int_clr & reg_wdata[gi]) begin
          int_stat_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |(int_stat_q & int_en_q);

  assign ctrl_view = {6'h00, msel_q, ack_val_q};
  assign stat_view = {3'h0, hdr_q[0] & aat_q, ack_missing, busy_q, aat_q,
                      int_stat_q[`SMBT_INT_DONE]};

  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_q <= `SMBT_BYTE_RST;
    end else if (reg_rd) begin
      case (reg_addr)
        `SMBT_ADDR_OWN: begin
          reg_rdata_q <= {own_q, 1'b0};
        end
        `SMBT_ADDR_CTRL: begin
          reg_rdata_q <= ctrl_view;
        end
        `SMBT_ADDR_STAT: begin
          reg_rdata_q <= stat_view;
        end
        `SMBT_ADDR_DATA: begin
          reg_rdata_q <= data_q;
        end
        `SMBT_ADDR_INT_STAT: begin
          reg_rdata_q <= {4'h0, int_stat_q};
        end
        `SMBT_ADDR_INT_EN: begin
          reg_rdata_q <= {4'h0, int_en_q};
        end
        default: begin
          reg_rdata_q <= `SMBT_BYTE_RST;
        end
      endcase
    end
  end

endmodule // smbt_byte_flow

`default_nettype wire

/* File: verif/smbt_byte_flow_chk.sv */
`include "smbt_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module smbt_byte_flow_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Host port
  input wire logic [`SMBT_AW-1:0] reg_addr,
  input wire logic [`SMBT_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`SMBT_DW-1:0] reg_rdata_q,
  input wire logic irq,
  // Lines and generator requests
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n_q,
  input wire logic gen_start_req,
  input wire logic gen_stop_req
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic [3:0] lo_cnt_q;

  // Cycles since the raw clock line went low, so line actions can be tied to a fall.
  always @(posedge clk_sys) begin
    if (rst || scl_in) begin
      lo_cnt_q <= 4'h0;
    end else if (lo_cnt_q != 4'hf) begin
      lo_cnt_q <= lo_cnt_q + 4'h1;
    end
  end

  sequence s_mask_all;
    reg_wr && reg_addr == `SMBT_ADDR_INT_EN && reg_wdata[3:0] == 4'h0;
  endsequence

  sequence s_rd_from(logic [3:0] a);
    reg_rd && reg_addr == a;
  endsequence

  a_stop_one_cycle: assert property (gen_stop_req |=> !gen_stop_req)
    else $error("stop request held longer than one cycle");
  a_stop_at_fall: assert property (gen_stop_req |-> lo_cnt_q inside {[1:10]})
    else $error("stop request not tied to a clock fall");
  a_oe_on_fall: assert property ($changed(sda_oe_n_q) |-> lo_cnt_q inside {[2:10]})
    else $error("data drive changed away from a clock fall");
  a_oe_reset_free: assert property ($fell(rst) |-> sda_oe_n_q)
    else $error("data line driven right after reset");
  a_od_low_only: assert property (sda_out == 1'b0)
    else $error("open drain data level not low");
  a_irq_masked: assert property (s_mask_all |=> !irq)
    else $error("interrupt stands with all enables cleared");
  a_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata_q))
    else $error("read data moved without a read");
  a_own_bit_zero: assert property (s_rd_from(`SMBT_ADDR_OWN) |=> !reg_rdata_q[0])
    else $error("own address bit 0 not zero");
endmodule // smbt_byte_flow_chk

`default_nettype wire

/* File: verif/smbt_bus_model.sv */
`timescale 1ns/10ps
`default_nettype none

module smbt_bus_model (
  // Lines
  output logic scl,
  output logic sda_oe_n,
  input wire logic sda_line
);
  localparam int Q = 40;

  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end

  // Data falls while the clock is high.
  task automatic start_c();
    sda_oe_n = 1'b1;
    scl = 1'b1;
    #Q;
    sda_oe_n = 1'b0;
    #Q;
    scl = 1'b0;
    #Q;
  endtask

  // Data rises while the clock is high; the clock then stands still.
  task automatic stop_c();
    sda_oe_n = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda_oe_n = 1'b1;
    #(2*Q);
  endtask

  task automatic bit_c(input logic b, output logic r);
    sda_oe_n = b;
    #Q;
    scl = 1'b1;
    #Q;
    r = sda_line;
    #Q;
    scl = 1'b0;
    #Q;
  endtask

  task automatic byte_c(input logic [7:0] tx, input logic ack, output logic [7:0] rx,
                        output logic ack_seen);
    for (int i = 7; i >= 0; i--) begin
      bit_c(tx[i], rx[i]);
    end
    bit_c(ack, ack_seen);
  endtask
endmodule // smbt_bus_model

`default_nettype wire

/* File: verif/smbt_byte_flow_tb.sv */
`include "smbt_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module smbt_byte_flow_tb;
  logic clk_sys, rst, reg_wr, reg_rd, ak;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, rx, v;
  wire logic [7:0] reg_rdata_q;
  wire logic irq, scl, sda_out, sda_oe_n_q, gen_start_req, gen_stop_req, m_oe_n;
  wire logic sda_line = m_oe_n & (sda_oe_n_q | sda_out);
  int bad_count, tests_run, stop_n;

  smbt_byte_flow i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .irq(irq), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n_q(sda_oe_n_q),
    .gen_start_req(gen_start_req), .gen_stop_req(gen_stop_req));
  smbt_bus_model i_bus (.scl(scl), .sda_oe_n(m_oe_n), .sda_line(sda_line));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (gen_stop_req === 1'b1) stop_n <= stop_n + 1;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // Return off the sampling edge so that line activity that follows never races it.
    @(negedge clk_sys);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata_q;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wait_irq();
    int n;
    for (n = 0; n < 300 && irq !== 1'b1; n++) @(negedge clk_sys);
    chk("irq_tx", 8'h01, {7'h0, irq});
  endtask

  task automatic print_verdict();
    $display("TB: %0d checks, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    // Target receive, own address 7'h2a, two bytes with no host service between.
    wr(`SMBT_ADDR_OWN, 8'h54);
    rd(`SMBT_ADDR_OWN, v);
    chk("own_addr", 8'h54, v);
    wr(`SMBT_ADDR_INT_EN, 8'h01);
    rd(`SMBT_ADDR_DATA, v);
    i_bus.start_c();
    i_bus.byte_c(8'h54, 1'b1, rx, ak);
    chk("hdr_ack", 8'h00, {7'h0, ak});
    rd(`SMBT_ADDR_STAT, v);
    chk("stat_hdr", 8'h06, v & 8'h06);
    i_bus.byte_c(8'h3c, 1'b1, rx, ak);
    chk("rx1_ack", 8'h00, {7'h0, ak});
    i_bus.byte_c(8'hc3, 1'b1, rx, ak);
    rd(`SMBT_ADDR_DATA, v);
    chk("rx2_data", 8'hc3, v);
    chk("irq_rx", 8'h01, {7'h0, irq});
    wr(`SMBT_ADDR_INT_CLR, 8'h01);
    rd(`SMBT_ADDR_STAT, v);
    chk("irq_clr", 8'h00, {7'h0, irq});
    wr(`SMBT_ADDR_INT_EN, 8'h00);
    wr(`SMBT_ADDR_CTRL, 8'h01);
    i_bus.byte_c(8'h81, 1'b1, rx, ak);
    chk("rx3_nak", 8'h01, {7'h0, ak});
    rd(`SMBT_ADDR_STAT, v);
    chk("done_noirq", 8'h01, v & 8'h01);
    chk("irq_off", 8'h00, {7'h0, irq});
    i_bus.stop_c();
    rd(`SMBT_ADDR_STAT, v);
    chk("stat_end", 8'h00, v & 8'h06);
    rd(`SMBT_ADDR_INT_STAT, v);
    chk("stop_seen", 8'h04, v & 8'h04);
    chk("no_stop_req", 8'h00, stop_n[7:0]);
    $display("test target_rx done");
    // Target transmit, next byte written during the acknowledge slot.
    wr(`SMBT_ADDR_CTRL, 8'h00);
    wr(`SMBT_ADDR_INT_CLR, 8'h0f);
    wr(`SMBT_ADDR_INT_EN, 8'h01);
    wr(`SMBT_ADDR_DATA, 8'h96);
    i_bus.start_c();
    i_bus.byte_c(8'h55, 1'b1, rx, ak);
    fork
      i_bus.byte_c(8'hff, 1'b0, rx, ak);
      begin
        wait_irq();
        wr(`SMBT_ADDR_DATA, 8'h5a);
        wr(`SMBT_ADDR_INT_CLR, 8'h01);
      end
    join
    chk("tx1", 8'h96, rx);
    i_bus.byte_c(8'hff, 1'b1, rx, ak);
    chk("tx2", 8'h5a, rx);
    rd(`SMBT_ADDR_INT_STAT, v);
    chk("tx_nak", 8'h09, v & 8'h09);
    i_bus.stop_c();
    $display("test target_tx done");
    // Controller header refused by the far side.
    wr(`SMBT_ADDR_DATA, 8'ha4);
    wr(`SMBT_ADDR_CTRL, 8'h02);
    @(negedge clk_sys);
    chk("start_req", 8'h01, {7'h0, gen_start_req});
    i_bus.start_c();
    i_bus.byte_c(8'hff, 1'b1, rx, ak);
    chk("hdr_out", 8'ha4, rx);
    i_bus.stop_c();
    chk("stop_req", 8'h01, stop_n[7:0]);
    $display("test controller done");
    // Controller receive of one byte, last byte refused, STOP asked by clearing the select.
    wr(`SMBT_ADDR_DATA, 8'h61);
    i_bus.start_c();
    i_bus.byte_c(8'hff, 1'b0, rx, ak);
    chk("hdr_rd", 8'h61, rx);
    wr(`SMBT_ADDR_CTRL, 8'h01);
    i_bus.byte_c(8'h5c, 1'b1, rx, ak);
    chk("crx_nak", 8'h01, {7'h0, ak});
    rd(`SMBT_ADDR_DATA, v);
    chk("crx_data", 8'h5c, v);
    chk("stop_req2", 8'h02, stop_n[7:0]);
    i_bus.stop_c();
    $display("test controller_rx done");
    print_verdict();
  end
endmodule // smbt_byte_flow_tb

bind smbt_byte_flow smbt_byte_flow_chk i_chk (.clk_sys(clk_sys), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .irq(irq), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n_q(sda_oe_n_q), .gen_start_req(gen_start_req), .gen_stop_req(gen_stop_req));

`default_nettype wire
